// ### rtl/dsg_defines.vh
// register map, field positions and reset values of the clock gating block
`ifndef DSG_DEFINES_VH
`define DSG_DEFINES_VH

// system control base address, byte offsets below are relative to it
`define DSG_BASE_ADDR 32'h400FE000
`define DSG_ADDR_W 12

// register byte offsets
`define DSG_OFF_RUN_CFG 12'h060
`define DSG_OFF_RUN_GATE 12'h100
`define DSG_OFF_SLEEP_GATE 12'h110
`define DSG_OFF_DEEP_GATE 12'h120
`define DSG_OFF_IRQ_STATUS 12'h130
`define DSG_OFF_IRQ_CLEAR 12'h134
`define DSG_OFF_IRQ_ENABLE 12'h138

// gating bit positions
`define DSG_BIT_CAN 24
`define DSG_BIT_PWM 20
`define DSG_BIT_ADC 16
`define DSG_BIT_KEEPER 6
`define DSG_BIT_WATCHDOG 3

// run clock configuration field
`define DSG_BIT_AUTO_GATE 0

// writable gating bits and reset values
`define DSG_GATE_MASK 32'h01110048
`define DSG_GATE_RESET 32'h00000040
`define DSG_RUN_CFG_RESET 32'h00000000
`define DSG_RUN_CFG_MASK 32'h00000001

// unit index inside the per-unit vectors
`define DSG_UNITS 5
`define DSG_U_WATCHDOG 0
`define DSG_U_KEEPER 1
`define DSG_U_ADC 2
`define DSG_U_PWM 3
`define DSG_U_CAN 4

// power states
`define DSG_MODE_RUN 2'h0
`define DSG_MODE_SLEEP 2'h1
`define DSG_MODE_DEEP 2'h2

`endif

// ### rtl/dsg_gate_sel.v
// registered selection of the active gating set per unit
`timescale 1ns/1ns
`default_nettype none
`include "dsg_defines.vh"

module dsg_gate_sel #(
  parameter N = 5
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // gating sets and state
  input wire [N-1:0] run_en,
  input wire [N-1:0] sleep_en,
  input wire [N-1:0] deep_en,
  input wire auto_gate,
  input wire [1:0] mode,
  // unit clock enables
  output reg [N-1:0] unit_en_q,
  output reg [1:0] mode_q
);

  reg [N-1:0] unit_en_d;

  always @*
  begin
    unit_en_d = run_en;
    if (auto_gate && mode == `DSG_MODE_DEEP)
      unit_en_d = deep_en;
    else if (auto_gate && mode == `DSG_MODE_SLEEP)
      unit_en_d = sleep_en;
  end

  // only flops change the enables, so a set switch cannot glitch a unit
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_en_q <= {N{1'b0}};
      unit_en_q[`DSG_U_KEEPER] <= 1'b1;
      mode_q <= `DSG_MODE_RUN;
    end
    else
    begin
      unit_en_q <= unit_en_d;
      mode_q <= mode;
    end
  end

endmodule

`default_nettype wire

// ### rtl/dsg_clock_gate_ctrl.v
// deep-sleep clock gating control with run and sleep sets and bus fault check
`timescale 1ns/1ns
`default_nettype none
`include "dsg_defines.vh"

module dsg_clock_gate_ctrl (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // system power state
  input wire sys_sleep,
  input wire sys_deep_sleep,
  // unit clock enables, 0 watchdog 1 keeper 2 sampler 3 modulator 4 can
  output wire [4:0] unit_clk_en,
  // unit access check
  input wire [4:0] unit_access,
  output reg [4:0] unit_fault_q,
  output reg [4:0] unit_ok_q,
  // interrupt
  output wire irq
);

  // register file
  reg [31:0] run_gate_reg0_q;
  reg [31:0] sleep_gate_reg0_q;
  reg [31:0] deep_sleep_gate_reg0_q;
  reg [31:0] run_clock_config_q;
  reg [31:0] irq_status_q;
  reg [31:0] irq_enable_q;

  // bus side
  reg ack_q;
  reg [31:0] rd_d;
  reg [31:0] be_mask;
  wire req;
  wire wr_now;
  wire wr_cfg;
  wire wr_run;
  wire wr_sleep;
  wire wr_deep;
  wire wr_en;
  wire wr_clr;
  wire [31:0] wmerge_run;
  wire [31:0] wmerge_sleep;
  wire [31:0] wmerge_deep;
  wire [31:0] wmerge_en;

  // unit side
  reg [1:0] mode;
  reg [31:0] irq_status_d;
  wire auto_gate;
  wire [4:0] run_units;
  wire [4:0] sleep_units;
  wire [4:0] deep_units;
  wire [4:0] fault_units;
  wire [31:0] fault_bits;
  wire [31:0] clr_bits;
  wire [31:0] irq_pending;

  // register layout to unit vector
  function [4:0] to_units;
    input [31:0] r;
    begin
      to_units = 5'h00;
      to_units[`DSG_U_CAN] = r[`DSG_BIT_CAN];
      to_units[`DSG_U_PWM] = r[`DSG_BIT_PWM];
      to_units[`DSG_U_ADC] = r[`DSG_BIT_ADC];
      to_units[`DSG_U_KEEPER] = r[`DSG_BIT_KEEPER];
      to_units[`DSG_U_WATCHDOG] = r[`DSG_BIT_WATCHDOG];
    end
  endfunction

  // unit vector to register layout
  function [31:0] to_reg;
    input [4:0] u;
    begin
      to_reg = 32'h00000000;
      to_reg[`DSG_BIT_CAN] = u[`DSG_U_CAN];
      to_reg[`DSG_BIT_PWM] = u[`DSG_U_PWM];
      to_reg[`DSG_BIT_ADC] = u[`DSG_U_ADC];
      to_reg[`DSG_BIT_KEEPER] = u[`DSG_U_KEEPER];
      to_reg[`DSG_BIT_WATCHDOG] = u[`DSG_U_WATCHDOG];
    end
  endfunction

  // byte-enable merge of a write into a gating register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] bm;
    begin
      merge = ((old & ~bm) | (wd & bm)) & `DSG_GATE_MASK;
    end
  endfunction

  // offset match of the current request
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // byte lanes to a bit mask
  function [31:0] lanes;
    input [3:0] be;
    begin
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // bits that a read may show per offset, the rest read zero
  function [31:0] rd_mask;
    input [11:0] a;
    begin
      case (a)
        `DSG_OFF_RUN_CFG: rd_mask = `DSG_RUN_CFG_MASK;
        `DSG_OFF_RUN_GATE: rd_mask = `DSG_GATE_MASK;
        `DSG_OFF_SLEEP_GATE: rd_mask = `DSG_GATE_MASK;
        `DSG_OFF_DEEP_GATE: rd_mask = `DSG_GATE_MASK;
        `DSG_OFF_IRQ_STATUS: rd_mask = `DSG_GATE_MASK;
        `DSG_OFF_IRQ_ENABLE: rd_mask = `DSG_GATE_MASK;
        default: rd_mask = 32'h00000000;
      endcase
    end
  endfunction

  // one wait state: answer at the second edge of a request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_now = avs_write & ack_q;

  // per-register write strobes, taken at the answering edge
  assign wr_cfg = wr_now & hit(avs_address, `DSG_OFF_RUN_CFG);
  assign wr_run = wr_now & hit(avs_address, `DSG_OFF_RUN_GATE);
  assign wr_sleep = wr_now & hit(avs_address, `DSG_OFF_SLEEP_GATE);
  assign wr_deep = wr_now & hit(avs_address, `DSG_OFF_DEEP_GATE);
  assign wr_en = wr_now & hit(avs_address, `DSG_OFF_IRQ_ENABLE);
  assign wr_clr = wr_now & hit(avs_address, `DSG_OFF_IRQ_CLEAR);

  always @*
  begin
    be_mask = lanes(avs_byteenable);
  end

  assign wmerge_run = merge(run_gate_reg0_q, avs_writedata, be_mask);
  assign wmerge_sleep = merge(sleep_gate_reg0_q, avs_writedata, be_mask);
  assign wmerge_deep = merge(deep_sleep_gate_reg0_q, avs_writedata, be_mask);
  assign wmerge_en = merge(irq_enable_q, avs_writedata, be_mask);

  // read mux, unmapped offsets read zero
  always @*
  begin
    case (avs_address)
      `DSG_OFF_RUN_CFG: rd_d = run_clock_config_q;
      `DSG_OFF_RUN_GATE: rd_d = run_gate_reg0_q;
      `DSG_OFF_SLEEP_GATE: rd_d = sleep_gate_reg0_q;
      `DSG_OFF_DEEP_GATE: rd_d = deep_sleep_gate_reg0_q;
      `DSG_OFF_IRQ_STATUS: rd_d = irq_status_q;
      `DSG_OFF_IRQ_ENABLE: rd_d = irq_enable_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // read data loaded at the first edge of a read, while waitrequest is still high, stands until the next read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_q)
      avs_readdata <= rd_d & rd_mask(avs_address);
  end

  // run clock configuration, only the auto gate bit is kept
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_clock_config_q <= `DSG_RUN_CFG_RESET;
    else if (wr_cfg && avs_byteenable[0])
      run_clock_config_q <= avs_writedata & `DSG_RUN_CFG_MASK;
  end

  // run-mode set
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_gate_reg0_q <= `DSG_GATE_RESET;
    else if (wr_run)
      run_gate_reg0_q <= wmerge_run;
  end

  // sleep-mode set
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_gate_reg0_q <= `DSG_GATE_RESET;
    else if (wr_sleep)
      sleep_gate_reg0_q <= wmerge_sleep;
  end

  // deep-sleep set
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      deep_sleep_gate_reg0_q <= `DSG_GATE_RESET;
    else if (wr_deep)
      deep_sleep_gate_reg0_q <= wmerge_deep;
  end

  // interrupt enables, same layout as the gating sets
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_enable_q <= 32'h00000000;
    else if (wr_en)
      irq_enable_q <= wmerge_en;
  end

  assign auto_gate = run_clock_config_q[`DSG_BIT_AUTO_GATE];

  // power state code, deep sleep overrides sleep
  always @*
  begin
    if (sys_deep_sleep)
      mode = `DSG_MODE_DEEP;
    else if (sys_sleep)
      mode = `DSG_MODE_SLEEP;
    else
      mode = `DSG_MODE_RUN;
  end

  assign run_units = to_units(run_gate_reg0_q);
  assign sleep_units = to_units(sleep_gate_reg0_q);
  assign deep_units = to_units(deep_sleep_gate_reg0_q);

  dsg_gate_sel #(
    .N(`DSG_UNITS)
  ) u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .run_en(run_units),
    .sleep_en(sleep_units),
    .deep_en(deep_units),
    .auto_gate(auto_gate),
    .mode(mode),
    .unit_en_q(unit_clk_en),
    .mode_q()
  );

  // access check: gated unit answers fault, else ok, one cycle later
  assign fault_units = unit_access & ~unit_clk_en;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_fault_q <= 5'h00;
    else
      unit_fault_q <= fault_units;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_ok_q <= 5'h00;
    else
      unit_ok_q <= unit_access & unit_clk_en;
  end

  // sticky fault status, set wins over write-one clear
  assign fault_bits = to_reg(fault_units);
  assign clr_bits = wr_clr ? (avs_writedata & be_mask) : 32'h00000000;

  always @*
  begin
    irq_status_d = (irq_status_q & ~clr_bits) | fault_bits;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_q <= 32'h00000000;
    else
      irq_status_q <= irq_status_d;
  end

  assign irq_pending = irq_status_q & irq_enable_q;
  assign irq = |irq_pending;

endmodule

`default_nettype wire

// ### tb/dsg_gate_chk_sva.sv
// port assertions of the clock gating block
`timescale 1ns/1ns
`default_nettype none
module dsg_gate_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus and power state
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sys_sleep,
  input wire logic sys_deep_sleep,
  // units
  input wire logic [4:0] unit_access,
  input wire logic [4:0] unit_clk_en,
  input wire logic [4:0] unit_fault_q,
  input wire logic [4:0] unit_ok_q,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_idle_free: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait while idle");
  a_fault_match: assert property (unit_fault_q == ($past(unit_access) & ~$past(unit_clk_en)))
    else $error("fault pulse wrong");
  a_ok_match: assert property (unit_ok_q == ($past(unit_access) & $past(unit_clk_en)))
    else $error("ok pulse wrong");
  a_hib_reset: assert property ($rose(rst_n) |-> unit_clk_en == 5'h02)
    else $error("reset enables wrong");
  a_en_cause:
    assert property ($changed(unit_clk_en) |-> $past(avs_write, 2) || $past(sys_sleep) !=
      $past(sys_sleep, 2) || $past(sys_deep_sleep) != $past(sys_deep_sleep, 2))
    else $error("enables changed alone");
  a_irq_cause: assert property ($rose(irq) |-> |unit_fault_q || $past(avs_write))
    else $error("irq rose alone");
  a_irq_drop: assert property ($fell(irq) |-> $past(avs_write))
    else $error("irq fell alone");
endmodule
bind dsg_clock_gate_ctrl dsg_gate_chk i_chk (.*);
`default_nettype wire

// ### tb/dsg_sw_model.sv
// processor-side bus master model
`timescale 1ns/1ns
`default_nettype none
module dsg_sw_model (
  // clock
  input wire logic clk,
  // avalon-mm master
  output logic [11:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial
  begin
    {avs_address, avs_read, avs_write, avs_writedata} = 0;
    avs_byteenable = 4'hF;
  end
  task xfer(input logic w, logic [11:0] a, logic [31:0] d, logic [3:0] be,
            output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/deep_sleep_clock_gating_reg0_test.sv
// self-checking bench of the deep-sleep clock gating block
`timescale 1ns/1ns
`default_nettype none
module deep_sleep_clock_gating_reg0_test;
  logic clk, rst_n, sys_sleep, sys_deep_sleep, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] unit_access, unit_clk_en, unit_fault_q, unit_ok_q;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  int failures, checks_done;
  dsg_sw_model i_sw (.*);
  dsg_clock_gate_ctrl i_dut (.*);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, logic [31:0] d);
    i_sw.xfer(1'b1, a, d, 4'hF, q);
  endtask
  task rd(input logic [11:0] a, logic [31:0] e, string n);
    i_sw.xfer(1'b0, a, 32'h0, 4'hF, q);
    chk(n, e, q);
  endtask
  task mode(input logic s, logic d, logic [4:0] e);
    @(posedge clk);
    sys_sleep <= s;
    sys_deep_sleep <= d;
    repeat (3) @(negedge clk);
    chk("enables", {27'h0, e}, {27'h0, unit_clk_en});
  endtask
  task t_reset;
    rd(12'h120, 32'h40, "deep reset");
    rd(12'h100, 32'h40, "run reset");
    rd(12'h110, 32'h40, "sleep reset");
    rd(12'h060, 32'h0, "config reset");
    rd(12'h130, 32'h0, "status reset");
    chk("reset enables", 32'h2, {27'h0, unit_clk_en});
  endtask
  task t_mask;
    wr(12'h120, 32'hFFFFFFFF);
    rd(12'h120, 32'h01110048, "deep bits");
    i_sw.xfer(1'b1, 12'h120, 32'h0, 4'h1, q);
    rd(12'h120, 32'h01110000, "deep lane");
    wr(12'h120, 32'h01110048);
    rd(12'h200, 32'h0, "unmapped");
  endtask
  task t_modes;
    wr(12'h100, 32'h0);
    mode(1'b0, 1'b1, 5'h00);
    wr(12'h060, 32'h1);
    mode(1'b0, 1'b1, 5'h1F);
    wr(12'h110, 32'h00100040);
    mode(1'b1, 1'b0, 5'h0A);
    wr(12'h110, 32'h00000040);
    mode(1'b1, 1'b0, 5'h02);
    mode(1'b0, 1'b0, 5'h00);
  endtask
  task t_fault;
    mode(1'b1, 1'b0, 5'h02);
    wr(12'h138, 32'h01110048);
    @(posedge clk);
    unit_access <= 5'h1F;
    @(posedge clk);
    unit_access <= 5'h00;
    @(negedge clk);
    chk("faults", 32'h1D, {27'h0, unit_fault_q});
    chk("oks", 32'h02, {27'h0, unit_ok_q});
    rd(12'h130, 32'h01110008, "status");
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h134, 32'h01110048);
    rd(12'h130, 32'h0, "cleared");
    chk("irq off", 32'h0, {31'h0, irq});
  endtask
  task complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {rst_n, sys_sleep, sys_deep_sleep, unit_access} = 0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_mask;
    t_modes;
    t_fault;
    complete_run;
  end
  initial
  begin
    #100000;
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
